// ===== cmpctl_bench.sv
`timescale 1ns/100ps
module cmpctl_bench;
   import cmpctl_pkg::*;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   logic pos_pin_in = 1'b0;
   logic neg_pin_in = 1'b0;
   logic irq_vector_ack = 1'b0;
   logic [7:0] v_pos = 8'h00;
   logic [7:0] v_neg = 8'h10;
   logic [7:0] v_bg = 8'hC0;
   logic [63:0] v_chan = 64'hD2B496785A3C1E00;
   logic hready, hreadyout, hresp, cmp_raw, cmp_irq_req, irq, cmp_power_off, bandgap_select;
   logic neg_use_channel, capture_route_enable, capture_input, pos_pin_buffer_off;
   logic neg_pin_buffer_off;
   logic [2:0] neg_channel;
   logic [1:0] pin_port_bits;
   logic [31:0] hrdata, r;
   logic [1:0] modes [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
   logic rise_f [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   logic fall_f [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   int n_errors = 0;
   int compares = 0;
   assign hready = hreadyout;
   always #50 clock = ~clock;
   cmpctl_top u_cmpctl_top (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_raw(cmp_raw),
      .pos_pin_in(pos_pin_in), .neg_pin_in(neg_pin_in), .irq_vector_ack(irq_vector_ack),
      .cmp_irq_req(cmp_irq_req), .irq(irq), .cmp_power_off(cmp_power_off),
      .bandgap_select(bandgap_select), .neg_use_channel(neg_use_channel),
      .neg_channel(neg_channel), .capture_route_enable(capture_route_enable),
      .capture_input(capture_input), .pos_pin_buffer_off(pos_pin_buffer_off),
      .neg_pin_buffer_off(neg_pin_buffer_off), .pin_port_bits(pin_port_bits));
   cmpctl_partner u_cmpctl_partner (.clock(clock), .power_off(cmp_power_off),
      .bandgap(bandgap_select), .use_chan(neg_use_channel), .chan(neg_channel),
      .v_pos(v_pos), .v_neg(v_neg), .v_bg(v_bg), .v_chan(v_chan), .cmp_raw(cmp_raw));
   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic finish_test();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic chk1(input logic seen, input logic exp);
      chk({31'h00000000, seen}, {31'h00000000, exp});
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic await_ready();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_errors++;
         finish_test();
      end
   endtask
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      await_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      await_ready();
      rd = hrdata;
      chk1(hresp, 1'b0);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] t;
      xfer(1'b1, {22'h000000, idx, 2'b00}, d, t);
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] d);
      xfer(1'b0, {22'h000000, idx, 2'b00}, 32'h00000000, d);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      step(10);
      reset <= 1'b0;
      step(1);
      rd(CMPCTL_IDX_CTRL_B, r);
      chk(r, 32'h00000000);
      rd(CMPCTL_IDX_STATUS, r);
      chk(r, 32'h00000000);
      rd(CMPCTL_IDX_DIS, r);
      chk(r, 32'h00000000);
      $display("reset values done");
      v_pos <= 8'h64;
      wr(CMPCTL_IDX_CTRL_B, 32'h000000FF);
      rd(CMPCTL_IDX_CTRL_B, r);
      chk(r, 32'h0000004F);
      for (int c = 0; c < 8; c++) begin
         wr(CMPCTL_IDX_CHAN, 32'(c));
         step(4);
         chk1(neg_use_channel, 1'b1);
         chk({29'h00000000, neg_channel}, 32'(c));
         rd(CMPCTL_IDX_STATUS, r);
         chk1(r[5], c < 4);
      end
      wr(CMPCTL_IDX_CONV_A, 32'h00000001 << CMPCTL_CONV_ON);
      step(4);
      chk1(neg_use_channel, 1'b0);
      rd(CMPCTL_IDX_STATUS, r);
      chk1(r[5], 1'b1);
      wr(CMPCTL_IDX_CONV_A, 32'h00000000);
      wr(CMPCTL_IDX_CTRL_B, 32'h00000000);
      step(4);
      chk1(neg_use_channel, 1'b0);
      $display("negative input mux done");
      v_pos <= 8'h00;
      wr(CMPCTL_IDX_STATUS, 32'h00000040);
      step(4);
      chk1(bandgap_select, 1'b1);
      rd(CMPCTL_IDX_STATUS, r);
      chk(r & 32'hFFFFFFEF, 32'h00000060);
      xfer(1'b0, 32'h00000540, 32'h00000000, r);
      chk(r, 32'h00000000);
      v_pos <= 8'hFF;
      wr(CMPCTL_IDX_STATUS, 32'h00000080);
      step(4);
      chk1(cmp_power_off, 1'b1);
      rd(CMPCTL_IDX_STATUS, r);
      chk1(r[5], 1'b0);
      wr(CMPCTL_IDX_STATUS, 32'h00000000);
      v_pos <= 8'h00;
      step(6);
      $display("bandgap and power done");
      for (int m = 0; m < 4; m++) begin
         wr(CMPCTL_IDX_STATUS, {28'h0000001, 2'b00, modes[m]});
         wr(CMPCTL_IDX_STATUS, {28'h0000001, 2'b00, modes[m]});
         v_pos <= 8'hFF;
         step(6);
         rd(CMPCTL_IDX_STATUS, r);
         chk1(r[4], rise_f[m]);
         wr(CMPCTL_IDX_STATUS, {28'h0000001, 2'b00, modes[m]});
         step(1);
         rd(CMPCTL_IDX_STATUS, r);
         chk1(r[4], 1'b0);
         v_pos <= 8'h00;
         step(6);
         rd(CMPCTL_IDX_STATUS, r);
         chk1(r[4], fall_f[m]);
      end
      $display("edge modes done");
      wr(CMPCTL_IDX_STATUS, 32'h00000013);
      wr(CMPCTL_IDX_IRQ_MASK, 32'h00000001);
      rd(CMPCTL_IDX_IRQ_ST, r);
      v_pos <= 8'hFF;
      step(6);
      chk1(irq, 1'b1);
      chk1(cmp_irq_req, 1'b0);
      wr(CMPCTL_IDX_STATUS, 32'h0000000B);
      step(1);
      chk1(cmp_irq_req, 1'b0);
      wr(CMPCTL_IDX_GIE, 32'h00000001 << CMPCTL_GIE_BIT);
      step(1);
      chk1(cmp_irq_req, 1'b1);
      rd(CMPCTL_IDX_IRQ_ST, r);
      chk1(r[0], 1'b1);
      step(1);
      chk1(irq, 1'b0);
      irq_vector_ack <= 1'b1;
      step(1);
      irq_vector_ack <= 1'b0;
      step(1);
      chk1(cmp_irq_req, 1'b0);
      rd(CMPCTL_IDX_STATUS, r);
      chk1(r[4], 1'b0);
      wr(CMPCTL_IDX_STATUS, 32'h00000003);
      wr(CMPCTL_IDX_IRQ_MASK, 32'h00000000);
      v_pos <= 8'h00;
      step(6);
      v_pos <= 8'hFF;
      step(6);
      chk1(irq, 1'b0);
      rd(CMPCTL_IDX_IRQ_ST, r);
      chk1(r[0], 1'b1);
      $display("interrupt request done");
      wr(CMPCTL_IDX_STATUS, 32'h00000004);
      step(1);
      chk1(capture_route_enable, 1'b1);
      chk1(capture_input, 1'b1);
      v_pos <= 8'h00;
      step(6);
      chk1(capture_input, 1'b0);
      rd(CMPCTL_IDX_IRQ_ST, r);
      chk(r, 32'h00000003);
      v_pos <= 8'hFF;
      step(6);
      wr(CMPCTL_IDX_STATUS, 32'h00000000);
      step(1);
      chk1(capture_input, 1'b0);
      $display("capture route done");
      pos_pin_in <= 1'b1;
      neg_pin_in <= 1'b1;
      step(4);
      chk({30'h00000000, pin_port_bits}, 32'h00000003);
      wr(CMPCTL_IDX_DIS, 32'h00000003);
      step(2);
      chk({30'h00000000, pin_port_bits}, 32'h00000000);
      chk({30'h00000000, neg_pin_buffer_off, pos_pin_buffer_off}, 32'h00000003);
      wr(CMPCTL_IDX_DIS, 32'h00000001);
      step(2);
      chk({30'h00000000, pin_port_bits}, 32'h00000002);
      rd(CMPCTL_IDX_DIS, r);
      chk(r, 32'h00000001);
      $display("input buffers done");
      finish_test();
   end
endmodule

// ===== cmpctl_edge.sv
`timescale 1ns/100ps
module cmpctl_edge
   import cmpctl_pkg::*;
(
   input wire logic clock, // System clock
   input wire logic reset, // Synchronous reset
   input wire logic cmp_raw, // Comparator analog output
   cmpctl_evt_if.det ev // Event carrier
);
   logic sync_meta;
   logic sync_out;
   logic prev_out;
   logic next_match;

   // ----------------------------------------------------------------
   // Two-stage synchroniser and history
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         sync_meta <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         sync_meta <= cmp_raw;
         sync_out <= sync_meta;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         prev_out <= 1'b0;
      end else begin
         prev_out <= sync_out;
      end
   end

   // ----------------------------------------------------------------
   // Edge mode match
   // ----------------------------------------------------------------
   always_comb begin
      next_match = 1'b0;
      case (ev.mode)
         CMPCTL_MODE_TOGGLE: next_match = sync_out ^ prev_out;
         CMPCTL_MODE_FALL: next_match = prev_out & ~sync_out;
         CMPCTL_MODE_RISE: next_match = sync_out & ~prev_out;
         default: next_match = 1'b0;
      endcase
   end

   assign ev.cmp_sync = sync_out;
   assign ev.cmp_change = sync_out ^ prev_out;
   assign ev.match_event = next_match;

   AST_SYNC_DELAY: assert property (@(posedge clock) disable iff (reset)
      ##2 (sync_out == $past(cmp_raw, 2))) else $error("sync delay not two edges");
   AST_FALL_EDGE: assert property (@(posedge clock) disable iff (reset)
      (ev.mode == CMPCTL_MODE_FALL && next_match) |-> ($past(sync_out) && !sync_out))
      else $error("falling mode event without falling edge");
   AST_RSVD_SILENT: assert property (@(posedge clock) disable iff (reset)
      (ev.mode == CMPCTL_MODE_RSVD) |-> !next_match) else $error("reserved mode event");
endmodule

// ===== cmpctl_evt_if.sv
`timescale 1ns/100ps
interface cmpctl_evt_if;
   import cmpctl_pkg::*;
   cmpctl_mode_t mode;
   logic cmp_sync;
   logic cmp_change;
   logic match_event;
   modport det (input mode, output cmp_sync, output cmp_change, output match_event);
   modport ctl (output mode, input cmp_sync, input cmp_change, input match_event);
endinterface

// ===== cmpctl_partner.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Comparator core model
// ----------------------------------------------------------------
module cmpctl_partner (
   input wire logic clock, // System clock
   input wire logic power_off, // Core powered down
   input wire logic bandgap, // Bandgap on positive input
   input wire logic use_chan, // Channel on negative input
   input wire logic [2:0] chan, // Selected channel
   input wire logic [7:0] v_pos, // Positive pin level
   input wire logic [7:0] v_neg, // Negative pin level
   input wire logic [7:0] v_bg, // Bandgap level
   input wire logic [63:0] v_chan, // Channel levels
   output logic cmp_raw // Comparator result
);
   logic [7:0] p;
   logic [7:0] n;
   assign p = bandgap ? v_bg : v_pos;
   assign n = use_chan ? v_chan[chan * 8 +: 8] : v_neg;
   always @(posedge clock) begin
      cmp_raw <= power_off ? 1'b0 : (p > n);
   end
endmodule

// ===== cmpctl_pkg.sv
package cmpctl_pkg;
   // ----------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0] CMPCTL_IDX_CTRL_B = 8'h7B;
   localparam logic [7:0] CMPCTL_IDX_STATUS = 8'h50;
   localparam logic [7:0] CMPCTL_IDX_DIS = 8'h51;
   localparam logic [7:0] CMPCTL_IDX_CONV_A = 8'h52;
   localparam logic [7:0] CMPCTL_IDX_CHAN = 8'h53;
   localparam logic [7:0] CMPCTL_IDX_GIE = 8'h54;
   localparam logic [7:0] CMPCTL_IDX_IRQ_ST = 8'h60;
   localparam logic [7:0] CMPCTL_IDX_IRQ_MASK = 8'h61;
   // ----------------------------------------------------------------
   // Field positions, masks and reset values
   // ----------------------------------------------------------------
   localparam int CMPCTL_CTRLB_MUX_EN = 6;
   localparam logic [7:0] CMPCTL_CTRLB_WMASK = 8'h4F;
   localparam logic [7:0] CMPCTL_CTRLB_RESET = 8'h00;
   localparam int CMPCTL_ST_PWR_OFF = 7;
   localparam int CMPCTL_ST_BANDGAP = 6;
   localparam int CMPCTL_ST_OUTPUT = 5;
   localparam int CMPCTL_ST_FLAG = 4;
   localparam int CMPCTL_ST_IE = 3;
   localparam int CMPCTL_ST_CAPTURE = 2;
   localparam int CMPCTL_ST_MODE_HI = 1;
   localparam int CMPCTL_ST_MODE_LO = 0;
   localparam int CMPCTL_CONV_ON = 0;
   localparam int CMPCTL_GIE_BIT = 0;
   localparam int CMPCTL_DIS_NEG = 1;
   localparam int CMPCTL_DIS_POS = 0;
   localparam int CMPCTL_EV_FLAG = 0;
   localparam int CMPCTL_EV_CAPTURE = 1;
   localparam int CMPCTL_EV_BITS = 2;
   localparam int CMPCTL_PIN_COUNT = 2;
   localparam logic [31:0] CMPCTL_ZERO_WORD = 32'h00000000;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CMPCTL_MODE_TOGGLE = 2'b00,
      CMPCTL_MODE_RSVD = 2'b01,
      CMPCTL_MODE_FALL = 2'b10,
      CMPCTL_MODE_RISE = 2'b11
   } cmpctl_mode_t;
   typedef enum logic [0:0] {
      CMPCTL_BUS_IDLE = 1'b0,
      CMPCTL_BUS_RD_WAIT = 1'b1
   } cmpctl_bus_t;
endpackage

// ===== cmpctl_top.sv
`timescale 1ns/100ps
module cmpctl_top
   import cmpctl_pkg::*;
(
   input wire logic clock, // System clock, 10 MHz
   input wire logic reset, // Synchronous reset, active high
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size, word only
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB bus ready
   output logic hreadyout, // AHB slave ready
   output logic hresp, // AHB response, always OKAY
   output logic [31:0] hrdata, // AHB read data
   input wire logic cmp_raw, // Comparator analog result
   input wire logic pos_pin_in, // Positive pin digital level
   input wire logic neg_pin_in, // Negative pin digital level
   input wire logic irq_vector_ack, // Comparator vector executed
   output logic cmp_irq_req, // Comparator interrupt request
   output logic irq, // Summary interrupt
   output logic cmp_power_off, // Comparator power down
   output logic bandgap_select, // Bandgap on positive input
   output logic neg_use_channel, // Channel mux on negative input
   output logic [2:0] neg_channel, // Channel for negative input
   output logic capture_route_enable, // Route output to capture
   output logic capture_input, // Timer capture input
   output logic pos_pin_buffer_off, // Positive pin buffer disabled
   output logic neg_pin_buffer_off, // Negative pin buffer disabled
   output logic [1:0] pin_port_bits // Port input bits, neg and pos
);
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0] converter_control_b;
   logic cmp_irq_flag;
   logic cmp_irq_enable;
   cmpctl_mode_t irq_mode;
   logic converter_on;
   logic [2:0] channel_select;
   logic [1:0] digital_input_disable_one;
   logic global_irq_enable;
   logic [CMPCTL_EV_BITS-1:0] irq_status;
   logic [CMPCTL_EV_BITS-1:0] irq_mask;
   cmpctl_bus_t bus_state;
   logic wr_pending;
   logic [7:0] wr_idx;
   logic wr_ok;
   logic [7:0] rd_idx;
   logic rd_ok;
   logic accept;
   logic wr_status;
   logic rd_status_clear;
   logic flag_clear;
   logic [CMPCTL_EV_BITS-1:0] ev_set;
   logic [CMPCTL_PIN_COUNT-1:0] pin_raw;
   logic [CMPCTL_PIN_COUNT-1:0] pin_meta;
   logic [CMPCTL_PIN_COUNT-1:0] pin_stage;
   logic [CMPCTL_PIN_COUNT-1:0] pin_off;

   cmpctl_evt_if ev ();

   cmpctl_edge u_edge (
      .clock(clock),
      .reset(reset),
      .cmp_raw(cmp_raw),
      .ev(ev)
   );

   assign ev.mode = irq_mode;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic reg_hit(input logic ok, input logic [7:0] idx,
                                    input logic [7:0] target);
      reg_hit = ok && (idx == target);
   endfunction

   function automatic logic [7:0] read_reg(input logic [7:0] idx);
      read_reg = 8'h00;
      case (idx)
         CMPCTL_IDX_CTRL_B: read_reg = converter_control_b;
         CMPCTL_IDX_STATUS: read_reg = {cmp_power_off, bandgap_select, ev.cmp_sync,
                                        cmp_irq_flag, cmp_irq_enable, capture_route_enable,
                                        irq_mode};
         CMPCTL_IDX_DIS: read_reg = {6'h00, digital_input_disable_one};
         CMPCTL_IDX_CONV_A: read_reg = 8'(converter_on) << CMPCTL_CONV_ON;
         CMPCTL_IDX_CHAN: read_reg = {5'h00, channel_select};
         CMPCTL_IDX_GIE: read_reg = 8'(global_irq_enable) << CMPCTL_GIE_BIT;
         CMPCTL_IDX_IRQ_ST: read_reg = {6'h00, irq_status};
         CMPCTL_IDX_IRQ_MASK: read_reg = {6'h00, irq_mask};
         default: read_reg = 8'h00;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   assign accept = hsel && hready && htrans[1];
   assign hreadyout = (bus_state != CMPCTL_BUS_RD_WAIT);
   assign hresp = 1'b0;

   always_ff @(posedge clock) begin
      if (reset) begin
         bus_state <= CMPCTL_BUS_IDLE;
      end else begin
         case (bus_state)
            CMPCTL_BUS_IDLE: begin
               if (accept && !hwrite) begin
                  bus_state <= CMPCTL_BUS_RD_WAIT;
               end
            end
            CMPCTL_BUS_RD_WAIT: bus_state <= CMPCTL_BUS_IDLE;
            default: bus_state <= CMPCTL_BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wr_pending <= 1'b0;
         wr_idx <= 8'h00;
         wr_ok <= 1'b0;
         rd_idx <= 8'h00;
         rd_ok <= 1'b0;
      end else begin
         wr_pending <= accept && hwrite;
         if (accept) begin
            wr_idx <= haddr[9:2];
            wr_ok <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
            rd_idx <= haddr[9:2];
            rd_ok <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         hrdata <= CMPCTL_ZERO_WORD;
      end else if (bus_state == CMPCTL_BUS_RD_WAIT) begin
         hrdata <= rd_ok ? {24'h000000, read_reg(rd_idx)} : CMPCTL_ZERO_WORD;
      end
   end

   assign wr_status = wr_pending && reg_hit(wr_ok, wr_idx, CMPCTL_IDX_STATUS);
   assign rd_status_clear = (bus_state == CMPCTL_BUS_RD_WAIT) &&
                            reg_hit(rd_ok, rd_idx, CMPCTL_IDX_IRQ_ST);

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         converter_control_b <= CMPCTL_CTRLB_RESET;
      end else if (wr_pending && reg_hit(wr_ok, wr_idx, CMPCTL_IDX_CTRL_B)) begin
         converter_control_b <= hwdata[7:0] & CMPCTL_CTRLB_WMASK;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         cmp_power_off <= 1'b0;
         bandgap_select <= 1'b0;
         cmp_irq_enable <= 1'b0;
         capture_route_enable <= 1'b0;
         irq_mode <= CMPCTL_MODE_TOGGLE;
      end else if (wr_status) begin
         cmp_power_off <= hwdata[CMPCTL_ST_PWR_OFF];
         bandgap_select <= hwdata[CMPCTL_ST_BANDGAP];
         cmp_irq_enable <= hwdata[CMPCTL_ST_IE];
         capture_route_enable <= hwdata[CMPCTL_ST_CAPTURE];
         irq_mode <= cmpctl_mode_t'(hwdata[CMPCTL_ST_MODE_HI:CMPCTL_ST_MODE_LO]);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         converter_on <= 1'b0;
         channel_select <= 3'h0;
         digital_input_disable_one <= 2'h0;
         global_irq_enable <= 1'b0;
         irq_mask <= '0;
      end else if (wr_pending) begin
         if (reg_hit(wr_ok, wr_idx, CMPCTL_IDX_CONV_A)) begin
            converter_on <= hwdata[CMPCTL_CONV_ON];
         end
         if (reg_hit(wr_ok, wr_idx, CMPCTL_IDX_CHAN)) begin
            channel_select <= hwdata[2:0];
         end
         if (reg_hit(wr_ok, wr_idx, CMPCTL_IDX_DIS)) begin
            digital_input_disable_one <= hwdata[1:0];
         end
         if (reg_hit(wr_ok, wr_idx, CMPCTL_IDX_GIE)) begin
            global_irq_enable <= hwdata[CMPCTL_GIE_BIT];
         end
         if (reg_hit(wr_ok, wr_idx, CMPCTL_IDX_IRQ_MASK)) begin
            irq_mask <= hwdata[CMPCTL_EV_BITS-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Comparator interrupt flag, set beats clear
   // ----------------------------------------------------------------
   assign flag_clear = irq_vector_ack || (wr_status && hwdata[CMPCTL_ST_FLAG]);

   always_ff @(posedge clock) begin
      if (reset) begin
         cmp_irq_flag <= 1'b0;
      end else begin
         cmp_irq_flag <= ev.match_event || (cmp_irq_flag && !flag_clear);
      end
   end

   assign cmp_irq_req = cmp_irq_flag && cmp_irq_enable && global_irq_enable;

   // ----------------------------------------------------------------
   // Sticky event status, cleared by read
   // ----------------------------------------------------------------
   assign ev_set[CMPCTL_EV_FLAG] = ev.match_event;
   assign ev_set[CMPCTL_EV_CAPTURE] = ev.cmp_change && capture_route_enable;

   always_ff @(posedge clock) begin
      if (reset) begin
         irq_status <= '0;
      end else begin
         irq_status <= ev_set | (rd_status_clear ? '0 : irq_status);
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ----------------------------------------------------------------
   // Analog input steering and capture route
   // ----------------------------------------------------------------
   assign neg_use_channel = converter_control_b[CMPCTL_CTRLB_MUX_EN] && !converter_on;
   assign neg_channel = neg_use_channel ? channel_select : 3'h0;
   assign capture_input = capture_route_enable && ev.cmp_sync;

   // ----------------------------------------------------------------
   // Pin input buffers
   // ----------------------------------------------------------------
   assign pin_raw = {neg_pin_in, pos_pin_in};
   assign pin_off = digital_input_disable_one;
   assign neg_pin_buffer_off = digital_input_disable_one[CMPCTL_DIS_NEG];
   assign pos_pin_buffer_off = digital_input_disable_one[CMPCTL_DIS_POS];

   genvar gi;
   generate
      for (gi = 0; gi < CMPCTL_PIN_COUNT; gi = gi + 1) begin : g_pin
         always_ff @(posedge clock) begin
            if (reset) begin
               pin_meta[gi] <= 1'b0;
               pin_stage[gi] <= 1'b0;
               pin_port_bits[gi] <= 1'b0;
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_stage[gi] <= pin_meta[gi];
               pin_port_bits[gi] <= pin_stage[gi] && !pin_off[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_NEG_CHANNEL: assert property (@(posedge clock) disable iff (reset)
      (converter_control_b[CMPCTL_CTRLB_MUX_EN] && !converter_on)
      |-> (neg_use_channel && neg_channel == channel_select))
      else $error("channel not routed to negative input");
   AST_NEG_PIN: assert property (@(posedge clock) disable iff (reset)
      (!converter_control_b[CMPCTL_CTRLB_MUX_EN] || converter_on) |-> !neg_use_channel)
      else $error("negative pin not selected");
   AST_CONV_ON_WRITE: assert property (@(posedge clock) disable iff (reset)
      (wr_pending && reg_hit(wr_ok, wr_idx, CMPCTL_IDX_CONV_A) && hwdata[CMPCTL_CONV_ON])
      |=> !neg_use_channel) else $error("converter on did not release mux");
   AST_POWER_OFF: assert property (@(posedge clock) disable iff (reset)
      wr_status |=> (cmp_power_off == $past(hwdata[CMPCTL_ST_PWR_OFF])))
      else $error("power off bit not taken");
   AST_BANDGAP: assert property (@(posedge clock) disable iff (reset)
      wr_status |=> (bandgap_select == $past(hwdata[CMPCTL_ST_BANDGAP])))
      else $error("bandgap select not taken");
   AST_FLAG_SET: assert property (@(posedge clock) disable iff (reset)
      ev.match_event |=> cmp_irq_flag) else $error("flag not set on event");
   AST_FLAG_ACK: assert property (@(posedge clock) disable iff (reset)
      (irq_vector_ack && !ev.match_event) |=> !cmp_irq_flag)
      else $error("flag not cleared by vector");
   AST_REQ_GATE: assert property (@(posedge clock) disable iff (reset)
      (!cmp_irq_enable || !global_irq_enable) |-> !cmp_irq_req)
      else $error("request while disabled");
   AST_CAPTURE_OFF: assert property (@(posedge clock) disable iff (reset)
      !capture_route_enable |-> !capture_input) else $error("capture route leaks");
   AST_PIN_MASK: assert property (@(posedge clock) disable iff (reset)
      (pin_off[0] && $stable(pin_off[0])) |=> !pin_port_bits[0])
      else $error("disabled pin reads one");
   AST_READ_WAIT: assert property (@(posedge clock) disable iff (reset)
      (accept && !hwrite && hreadyout) |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   AST_FLAG_SW_CLEAR: assert property (@(posedge clock) disable iff (reset)
      (wr_status && hwdata[CMPCTL_ST_FLAG] && !ev.match_event) |=> !cmp_irq_flag)
      else $error("flag not cleared by software write");
   AST_RSVD_NO_FLAG: assert property (@(posedge clock) disable iff (reset)
      (irq_mode == CMPCTL_MODE_RSVD && !cmp_irq_flag) |=> !cmp_irq_flag)
      else $error("reserved mode set the flag");
endmodule
